// ==== logic/pmic_regbank.sv ====
// What this block does
// - decode map from 0x02 up to 0x3A
// - thermal bit D1 set above 125C
// - delay preset in D6-4, resets 010
// - per-preset delays for each regulator
// - D2/D1 force PWM, reset 0
// - D0 selects external buck clock
// - enable bits D6,D4,D2,D0 reset 1
// - per-regulator valid flags, reset 0
// - D7 both bucks, D6 both linears
// - trigger rising edge starts sequence
// - answer only fixed seven-bit address
`timescale 1ns/1ps
`default_nettype none
`include "pmic_map.svh"

module pmic_regbank #(
  parameter int unsigned half_ms_cycles = `PMIC_HALF_MS_NS / `PMIC_CLK_NS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic seq_trigger,
  input wire pmic_pkg::pmic_reg_set_type ext_enable,
  input wire logic over_temp_in,
  input wire pmic_pkg::pmic_reg_set_type reg_valid_in,
  output pmic_pkg::pmic_reg_set_type reg_on,
  output logic buck_one_force_pwm,
  output logic buck_two_force_pwm,
  output logic external_buck_clock_select
);

  localparam int NSYNC = 12;
  localparam int NPLAIN = 10;

  // plain storage registers: address, writable mask, reset value
  localparam logic [NPLAIN-1:0][7:0] plain_addr = {
    `PMIC_ADDR_L2_VOLT, `PMIC_ADDR_L1_VOLT, `PMIC_ADDR_BFUNC,
    `PMIC_ADDR_B2_RAMP, `PMIC_ADDR_B2_TGT_B, `PMIC_ADDR_B2_TGT_A,
    `PMIC_ADDR_B1_RAMP, `PMIC_ADDR_B1_TGT_B, `PMIC_ADDR_B1_TGT_A,
    `PMIC_ADDR_VCHANGE};
  localparam logic [NPLAIN-1:0][7:0] plain_mask = {
    `PMIC_FULL_WMASK, `PMIC_FULL_WMASK, `PMIC_FULL_WMASK,
    `PMIC_RAMP_WMASK, `PMIC_TARGET_WMASK, `PMIC_TARGET_WMASK,
    `PMIC_RAMP_WMASK, `PMIC_TARGET_WMASK, `PMIC_TARGET_WMASK,
    `PMIC_VCHANGE_WMASK};
  localparam logic [NPLAIN-1:0][7:0] plain_reset = {
    `PMIC_PLAIN_RESET, `PMIC_PLAIN_RESET, `PMIC_PLAIN_RESET,
    `PMIC_RAMP_RESET, `PMIC_PLAIN_RESET, `PMIC_PLAIN_RESET,
    `PMIC_RAMP_RESET, `PMIC_PLAIN_RESET, `PMIC_PLAIN_RESET,
    `PMIC_PLAIN_RESET};

  // per preset: {linear two, linear one, buck two, buck one}
  localparam logic [7:0][19:0] delay_tab = {
    {`PMIC_DLY_11MS, `PMIC_DLY_6MS, `PMIC_DLY_3MS, `PMIC_DLY_2MS},
    {`PMIC_DLY_1M5, `PMIC_DLY_1MS, `PMIC_DLY_2MS, `PMIC_DLY_3MS},
    {`PMIC_DLY_2MS, `PMIC_DLY_2MS, `PMIC_DLY_1M5, `PMIC_DLY_1M5},
    {`PMIC_DLY_6MS, `PMIC_DLY_3MS, `PMIC_DLY_2MS, `PMIC_DLY_1M5},
    {`PMIC_DLY_1MS, `PMIC_DLY_1MS, `PMIC_DLY_2MS, `PMIC_DLY_1M5},
    {`PMIC_DLY_6MS, `PMIC_DLY_3MS, `PMIC_DLY_2MS, `PMIC_DLY_1M5},
    {`PMIC_DLY_2MS, `PMIC_DLY_2MS, `PMIC_DLY_1M5, `PMIC_DLY_1MS},
    {`PMIC_DLY_1MS, `PMIC_DLY_1MS, `PMIC_DLY_1MS, `PMIC_DLY_1MS}};

  // ---------------- pin synchronisers ----------------
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] sync3_q;
  logic [NSYNC-1:0] filt_q;
  logic [NSYNC-1:0] filt_d;

  assign pin_raw = {scl_i, sda_i, seq_trigger, over_temp_in, ext_enable, reg_valid_in};

  // a change is taken only once stages two and three agree
  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_filt
      assign filt_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : filt_q[i];
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= filt_d;
    end
  end

  // idle bus reads high; reset to zero so no false start at release
  wire logic scl_q = filt_q[11];
  wire logic scl_d = filt_d[11];
  wire logic sda_q = filt_q[10];
  wire logic sda_d = filt_d[10];
  wire logic trig_q = filt_q[9];
  wire logic trig_d = filt_d[9];
  wire logic hot_f = filt_q[8];
  wire pmic_pkg::pmic_reg_set_type ext_f = filt_q[7:4];
  wire pmic_pkg::pmic_reg_set_type valid_f = filt_q[3:0];

  wire logic scl_rise = !scl_q && scl_d;
  wire logic scl_fall = scl_q && !scl_d;
  wire logic bus_start = scl_q && scl_d && sda_q && !sda_d;
  wire logic bus_stop = scl_q && scl_d && !sda_q && sda_d;

  // ---------------- registers ----------------
  pmic_pkg::pmic_sysctl_type sysctl_q;
  pmic_pkg::pmic_enable_type enable_q;
  pmic_pkg::pmic_status_type status_q;
  pmic_pkg::pmic_thermal_type thermal_q;
  logic [NPLAIN-1:0][7:0] plain_q;

  logic wr_stb;
  logic [7:0] ptr_q;
  logic [7:0] shift_q;

  wire logic hit_sysctl = ptr_q == `PMIC_ADDR_SYSCTL;
  wire logic hit_enable = ptr_q == `PMIC_ADDR_ENABLE;
  wire logic hit_thermal = ptr_q == `PMIC_ADDR_THERMAL;
  wire logic hit_valid = ptr_q == `PMIC_ADDR_VALID;
  logic [NPLAIN-1:0] hit_plain;
  logic [NPLAIN-1:0][7:0] plain_rd;

  generate
    for (genvar i = 0; i < NPLAIN; i++) begin : g_plain
      assign hit_plain[i] = ptr_q == plain_addr[i];
      assign plain_rd[i] = hit_plain[i] ? plain_q[i] : 8'h00;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          plain_q[i] <= plain_reset[i];
        end else if (wr_stb && hit_plain[i]) begin
          plain_q[i] <= (plain_q[i] & ~plain_mask[i]) | (shift_q & plain_mask[i]);
        end
      end
    end
  endgenerate

  logic [7:0] plain_or;
  always_comb begin
    plain_or = 8'h00;
    for (int i = 0; i < NPLAIN; i++) begin
      plain_or = plain_or | plain_rd[i];
    end
  end

  // read mux; anything unmapped yields zero
  wire logic [7:0] rd_data = (hit_thermal ? 8'(thermal_q) : 8'h00)
                           | (hit_sysctl ? 8'(sysctl_q) : 8'h00)
                           | (hit_enable ? 8'(enable_q) : 8'h00)
                           | (hit_valid ? 8'(status_q) : 8'h00)
                           | plain_or;

  wire logic [7:0] sysctl_wr = (8'(sysctl_q) & ~`PMIC_SYSCTL_WMASK)
                             | (shift_q & `PMIC_SYSCTL_WMASK);
  wire logic [7:0] enable_wr = (8'(enable_q) & ~`PMIC_ENABLE_WMASK)
                             | (shift_q & `PMIC_ENABLE_WMASK);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sysctl_q <= `PMIC_SYSCTL_RESET;
      enable_q <= `PMIC_ENABLE_RESET;
    end else if (wr_stb) begin
      if (hit_sysctl) sysctl_q <= sysctl_wr;
      if (hit_enable) enable_q <= enable_wr;
    end
  end

  // status is sampled each cycle; read-only, so writes never reach it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= '0;
      thermal_q <= '0;
    end else begin
      thermal_q <= '{rsvd: 6'h00, over_temp: hot_f, rsvd0: 1'b0};
      status_q <= '{
        all_bucks_valid: valid_f.buck_one && valid_f.buck_two,
        all_linears_valid: valid_f.linear_one && valid_f.linear_two,
        linear_two_valid: valid_f.linear_two,
        linear_one_valid: valid_f.linear_one,
        rsvd3: 1'b0,
        buck_two_valid: valid_f.buck_two,
        rsvd1: 1'b0,
        buck_one_valid: valid_f.buck_one};
    end
  end

  assign buck_one_force_pwm = sysctl_q.buck_one_force_pwm;
  assign buck_two_force_pwm = sysctl_q.buck_two_force_pwm;
  assign external_buck_clock_select = sysctl_q.external_buck_clock_select;

  // ---------------- serial slave ----------------
  pmic_pkg::pmic_state_type state_q;
  pmic_pkg::pmic_state_type after_ack_q;
  logic [3:0] bits_q;

  wire logic byte_done = scl_fall && (bits_q == 4'h8);
  wire logic addr_match = shift_q[7:1] == `PMIC_I2C_ADDR;

  assign wr_stb = byte_done && (state_q == pmic_pkg::ST_WR);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= pmic_pkg::ST_IDLE;
      after_ack_q <= pmic_pkg::ST_IDLE;
      bits_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      sda_o <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (bus_start) begin
      state_q <= pmic_pkg::ST_DEV;
      bits_q <= 4'h0;
      sda_o <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (bus_stop) begin
      state_q <= pmic_pkg::ST_IDLE;
      sda_o <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      unique case (state_q)
        pmic_pkg::ST_IDLE: begin
          bits_q <= 4'h0;
        end
        pmic_pkg::ST_DEV, pmic_pkg::ST_REG, pmic_pkg::ST_WR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_q};
            bits_q <= bits_q + 4'h1;
          end else if (byte_done) begin
            bits_q <= 4'h0;
            if (state_q == pmic_pkg::ST_DEV && !addr_match) begin
              state_q <= pmic_pkg::ST_IDLE;
            end else begin
              state_q <= pmic_pkg::ST_ACK;
              sda_o <= 1'b0;
              sda_oe_n <= 1'b0;
            end
            if (state_q == pmic_pkg::ST_DEV) begin
              after_ack_q <= shift_q[0] ? pmic_pkg::ST_RD : pmic_pkg::ST_REG;
            end else begin
              after_ack_q <= pmic_pkg::ST_WR;
            end
            if (state_q == pmic_pkg::ST_REG) ptr_q <= shift_q;
            if (state_q == pmic_pkg::ST_WR) ptr_q <= ptr_q + 8'h01;
          end
        end
        pmic_pkg::ST_ACK: begin
          if (scl_fall) begin
            state_q <= after_ack_q;
            if (after_ack_q == pmic_pkg::ST_RD) begin
              shift_q <= rd_data;
              ptr_q <= ptr_q + 8'h01;
              sda_o <= rd_data[7];
              sda_oe_n <= rd_data[7];
            end else begin
              sda_o <= 1'b1;
              sda_oe_n <= 1'b1;
            end
          end
        end
        pmic_pkg::ST_RD: begin
          if (scl_fall) begin
            if (bits_q == 4'h7) begin
              state_q <= pmic_pkg::ST_MACK;
              bits_q <= 4'h0;
              sda_o <= 1'b1;
              sda_oe_n <= 1'b1;
            end else begin
              bits_q <= bits_q + 4'h1;
              shift_q <= {shift_q[6:0], 1'b0};
              sda_o <= shift_q[6];
              sda_oe_n <= shift_q[6];
            end
          end
        end
        pmic_pkg::ST_MACK: begin
          // a high level in the host's ack slot ends the read
          if (scl_rise && sda_q) begin
            state_q <= pmic_pkg::ST_IDLE;
          end else if (scl_fall) begin
            state_q <= pmic_pkg::ST_RD;
            shift_q <= rd_data;
            ptr_q <= ptr_q + 8'h01;
            sda_o <= rd_data[7];
            sda_oe_n <= rd_data[7];
          end
        end
        default: begin
          state_q <= pmic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------- power-on sequencer ----------------
  logic run_q;
  logic [15:0] tick_q;
  logic [4:0] half_q;
  logic [3:0] seq_q;

  wire logic trig_rise = !trig_q && trig_d;
  wire logic tick_wrap = tick_q == 16'(half_ms_cycles - 1);
  wire logic [19:0] cur_delay = delay_tab[sysctl_q.power_on_delay_preset];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= 1'b0;
      tick_q <= 16'h0000;
      half_q <= 5'h00;
    end else if (trig_rise) begin
      run_q <= 1'b1;
      tick_q <= 16'h0000;
      half_q <= 5'h00;
    end else if (run_q) begin
      tick_q <= tick_wrap ? 16'h0000 : tick_q + 16'h0001;
      if (tick_wrap) half_q <= half_q + 5'h01;
      if (half_q == `PMIC_DLY_11MS) run_q <= 1'b0;
    end
  end

  // falling trigger drops the sequenced enables at once
  generate
    for (genvar i = 0; i < 4; i++) begin : g_seq
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          seq_q[i] <= 1'b0;
        end else if (!trig_q || trig_rise) begin
          seq_q[i] <= 1'b0;
        end else if (run_q && half_q >= cur_delay[5*i +: 5]) begin
          seq_q[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // external pin enables bypass the sequence, so the host keeps them low
  wire pmic_pkg::pmic_reg_set_type sw_en = {enable_q.linear_two_enable,
    enable_q.linear_one_enable, enable_q.buck_two_enable, enable_q.buck_one_enable};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_on <= '0;
    end else begin
      reg_on <= sw_en & (ext_f | seq_q);
    end
  end

endmodule : pmic_regbank
`default_nettype wire

// ==== logic/pmic_map.svh ====
`ifndef PMIC_MAP_SVH
`define PMIC_MAP_SVH

// serial slave address
`define PMIC_I2C_ADDR 7'h60

// register offsets
`define PMIC_ADDR_THERMAL 8'h02
`define PMIC_ADDR_SYSCTL 8'h07
`define PMIC_ADDR_ENABLE 8'h10
`define PMIC_ADDR_VALID 8'h11
`define PMIC_ADDR_VCHANGE 8'h20
`define PMIC_ADDR_B1_TGT_A 8'h23
`define PMIC_ADDR_B1_TGT_B 8'h24
`define PMIC_ADDR_B1_RAMP 8'h25
`define PMIC_ADDR_B2_TGT_A 8'h29
`define PMIC_ADDR_B2_TGT_B 8'h2a
`define PMIC_ADDR_B2_RAMP 8'h2b
`define PMIC_ADDR_BFUNC 8'h38
`define PMIC_ADDR_L1_VOLT 8'h39
`define PMIC_ADDR_L2_VOLT 8'h3a

// reset values and writable bit masks
`define PMIC_SYSCTL_RESET 8'h28
`define PMIC_SYSCTL_WMASK 8'h77
`define PMIC_ENABLE_RESET 8'h75
`define PMIC_ENABLE_WMASK 8'h55
`define PMIC_VCHANGE_WMASK 8'h33
`define PMIC_TARGET_WMASK 8'h1f
`define PMIC_RAMP_WMASK 8'h0f
`define PMIC_FULL_WMASK 8'hff
`define PMIC_RAMP_RESET 8'h20
`define PMIC_PLAIN_RESET 8'h00

// timing
`define PMIC_CLK_NS 40
`define PMIC_HALF_MS_NS 500000

// power-on delays in half-millisecond steps
`define PMIC_DLY_1MS 5'h02
`define PMIC_DLY_1M5 5'h03
`define PMIC_DLY_2MS 5'h04
`define PMIC_DLY_3MS 5'h06
`define PMIC_DLY_6MS 5'h0c
`define PMIC_DLY_11MS 5'h16

`endif

// ==== logic/pmic_pkg.sv ====
`default_nettype none
package pmic_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_REG = 3'b010,
    ST_WR = 3'b011,
    ST_ACK = 3'b100,
    ST_RD = 3'b101,
    ST_MACK = 3'b110
  } pmic_state_type;

  // order: linear two, linear one, buck two, buck one
  typedef struct packed {
    logic linear_two;
    logic linear_one;
    logic buck_two;
    logic buck_one;
  } pmic_reg_set_type;

  typedef struct packed {
    logic rsvd7;
    logic [2:0] power_on_delay_preset;
    logic rsvd3;
    logic buck_two_force_pwm;
    logic buck_one_force_pwm;
    logic external_buck_clock_select;
  } pmic_sysctl_type;

  typedef struct packed {
    logic rsvd7;
    logic linear_two_enable;
    logic rsvd5;
    logic linear_one_enable;
    logic rsvd3;
    logic buck_two_enable;
    logic rsvd1;
    logic buck_one_enable;
  } pmic_enable_type;

  typedef struct packed {
    logic all_bucks_valid;
    logic all_linears_valid;
    logic linear_two_valid;
    logic linear_one_valid;
    logic rsvd3;
    logic buck_two_valid;
    logic rsvd1;
    logic buck_one_valid;
  } pmic_status_type;

  typedef struct packed {
    logic [5:0] rsvd;
    logic over_temp;
    logic rsvd0;
  } pmic_thermal_type;

endpackage : pmic_pkg
`default_nettype wire

// ==== tb/pmic_props_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmic_props #(
  parameter int unsigned half_ms_cycles = 12500
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic seq_trigger,
  input wire pmic_pkg::pmic_reg_set_type ext_enable,
  input wire pmic_pkg::pmic_reg_set_type reg_on,
  input wire logic buck_one_force_pwm,
  input wire logic buck_two_force_pwm,
  input wire logic external_buck_clock_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic [31:0] wait_q;
  wire logic [2:0] mode_w = {buck_two_force_pwm, buck_one_force_pwm,
    external_buck_clock_select};
  // lag of buck one behind a raised trigger
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wait_q <= 32'h0;
    else if (!seq_trigger || reg_on.buck_one) wait_q <= 32'h0;
    else wait_q <= wait_q + 32'h1;
  end
  a_reset_outputs_low: assert property ($rose(rstn) |-> reg_on == 4'h0 && mode_w == 3'h0)
    else $error("outputs not low after reset");
  a_quiet_when_off: assert property ((!seq_trigger && ext_enable == 4'h0) [*8] |-> reg_on == 4'h0)
    else $error("regulator on without cause");
  a_no_early_start: assert property ($rose(seq_trigger) && ext_enable == 4'h0 && reg_on == 4'h0
    |-> (reg_on == 4'h0) [*8])
    else $error("regulator on before shortest delay");
  a_seq_deadline: assert property (wait_q <= 6 * half_ms_cycles + 12)
    else $error("buck one late after trigger");
  a_fall_drops_seq: assert property ($fell(seq_trigger) && ext_enable == 4'h0
    |-> ##[1:8] reg_on == 4'h0)
    else $error("sequenced outputs kept after trigger fall");
  a_mode_scl_low: assert property ($changed(mode_w) |-> !scl_i)
    else $error("mode bits changed outside a write");
  a_ack_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("data line moved while clock high");
  a_open_drain_only: assert property (!sda_oe_n |-> !sda_o)
    else $error("data line driven high");
  c_seq_run: cover property ($rose(reg_on.linear_two));
  c_ack_seen: cover property ($fell(sda_oe_n));
  c_mode_set: cover property ($rose(buck_two_force_pwm));
endmodule : pmic_props
bind pmic_regbank pmic_props #(.half_ms_cycles(half_ms_cycles)) u_props (
  .clk(clk), .rstn(rstn), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .seq_trigger(seq_trigger), .ext_enable(ext_enable), .reg_on(reg_on),
  .buck_one_force_pwm(buck_one_force_pwm), .buck_two_force_pwm(buck_two_force_pwm),
  .external_buck_clock_select(external_buck_clock_select));
`default_nettype wire

// ==== tb/pmic_i2c_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmic_map.svh"
module pmic_i2c_host (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // four clocks a phase keeps each clock half above the pin filter delay
  task automatic ph(input logic c, input logic d);
    repeat (4) @(posedge clk);
    scl <= c;
    sda <= d;
  endtask : ph
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, b);
    ph(1'b1, b);
    repeat (4) @(posedge clk);
    r = sda_w;
    ph(1'b0, b);
  endtask : bit_io
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : put_byte
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
    output logic ok);
    logic a0, a1, a2;
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    put_byte({dev, 1'b0}, a0);
    put_byte(ra, a1);
    put_byte(d, a2);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ok = a0 & a1 & a2;
  endtask : wr
  task automatic rd(input logic [7:0] ra, output logic [7:0] d);
    logic a;
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    put_byte({`PMIC_I2C_ADDR, 1'b0}, a);
    put_byte(ra, a);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    put_byte({`PMIC_I2C_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, a);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask : rd
endmodule : pmic_i2c_host
`default_nettype wire

// ==== tb/tb_pmic_control_register_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmic_map.svh"
module tb_pmic_control_register_bank;
  localparam int unsigned hc = 16;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic seq_trigger = 1'b0;
  logic over_temp_in = 1'b0;
  pmic_pkg::pmic_reg_set_type ext_enable = 4'h0;
  pmic_pkg::pmic_reg_set_type reg_valid_in = 4'h0;
  pmic_pkg::pmic_reg_set_type reg_on;
  logic sda_o, sda_oe_n, scl_w, sda_h, pwm1, pwm2, eclk, ok;
  int err_total = 0;
  int cmp_count = 0;
  // pulled-up line, low when either side pulls
  wire logic sda_w = sda_h & (sda_oe_n | sda_o);
  logic [7:0] map_a [14] = '{8'h02, 8'h07, 8'h10, 8'h11, 8'h20, 8'h23, 8'h24, 8'h25,
    8'h29, 8'h2a, 8'h2b, 8'h38, 8'h39, 8'h3a};
  logic [7:0] map_r [14] = '{8'h00, 8'h28, 8'h75, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20,
    8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
  logic [7:0] map_m [14] = '{8'h00, 8'h77, 8'h55, 8'h00, 8'h33, 8'h1f, 8'h1f, 8'h0f,
    8'h1f, 8'h1f, 8'h0f, 8'hff, 8'hff, 8'hff};
  // half-ms steps per preset, bytes {linear two, linear one, buck two, buck one}
  logic [31:0] dly_t [8] = '{32'h02020202, 32'h04040302, 32'h0c060403, 32'h02020403,
    32'h0c060403, 32'h04040303, 32'h03020406, 32'h160c0604};
  always #20 clk = ~clk;
  pmic_regbank #(.half_ms_cycles(hc)) dut (.clk(clk), .rstn(rstn), .scl_i(scl_w),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .seq_trigger(seq_trigger),
    .ext_enable(ext_enable), .over_temp_in(over_temp_in), .reg_valid_in(reg_valid_in),
    .reg_on(reg_on), .buck_one_force_pwm(pwm1), .buck_two_force_pwm(pwm2),
    .external_buck_clock_select(eclk));
  pmic_i2c_host host (.clk(clk), .sda_w(sda_w), .scl(scl_w), .sda(sda_h));
  task automatic end_sim();
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  // on-time may trail the nominal count by filter and start-up cycles
  task automatic chk_dly(input logic [15:0] got, input logic [15:0] lo);
    cmp_count++;
    if (got >= lo && got <= lo + 16'h000c) cmp_count += 0;
    else begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, lo);
    end
  endtask : chk_dly
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk_reg(d, e);
  endtask : rd_chk
  task automatic t_map();
    foreach (map_a[i]) begin
      rd_chk(map_a[i], map_r[i]);
      host.wr(`PMIC_I2C_ADDR, map_a[i], 8'h00, ok);
      rd_chk(map_a[i], map_r[i] & ~map_m[i]);
      host.wr(`PMIC_I2C_ADDR, map_a[i], 8'hff, ok);
      rd_chk(map_a[i], map_r[i] & ~map_m[i] | map_m[i]);
    end
  endtask : t_map
  task automatic t_modes();
    for (int i = 0; i < 3; i++) begin
      host.wr(`PMIC_I2C_ADDR, 8'h07, 8'h28 | (8'h01 << i), ok);
      chk_reg({5'h00, pwm2, pwm1, eclk}, 8'h01 << i);
    end
    host.wr(`PMIC_I2C_ADDR, 8'h07, 8'h28, ok);
    chk_reg({5'h00, pwm2, pwm1, eclk}, 8'h00);
  endtask : t_modes
  task automatic t_unmapped();
    logic [7:0] gap_a [4] = '{8'h00, 8'h03, 8'h3b, 8'hff};
    host.wr(`PMIC_I2C_ADDR ^ 7'h01, 8'h07, 8'h00, ok);
    chk_reg({7'h00, ok}, 8'h00);
    rd_chk(8'h07, 8'h28);
    host.wr(`PMIC_I2C_ADDR, 8'h05, 8'hff, ok);
    chk_reg({7'h00, ok}, 8'h01);
    foreach (gap_a[i]) rd_chk(gap_a[i], 8'h00);
    rd_chk(8'h10, 8'h75);
  endtask : t_unmapped
  task automatic t_status();
    pmic_pkg::pmic_reg_set_type v;
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      reg_valid_in <= v;
      over_temp_in <= i[0];
      rd_chk(8'h11, {v.buck_one & v.buck_two, v.linear_one & v.linear_two, v.linear_two,
        v.linear_one, 1'b0, v.buck_two, 1'b0, v.buck_one});
      if (i < 2) rd_chk(8'h02, {6'h00, i[0], 1'b0});
    end
  endtask : t_status
  task automatic t_enables();
    host.wr(`PMIC_I2C_ADDR, 8'h10, 8'h15, ok);
    ext_enable <= 4'hf;
    repeat (10) @(posedge clk);
    chk_reg({4'h0, reg_on}, 8'h07);
    ext_enable <= 4'h0;
    host.wr(`PMIC_I2C_ADDR, 8'h10, 8'h55, ok);
    chk_reg({4'h0, reg_on}, 8'h00);
  endtask : t_enables
  task automatic t_sequence();
    logic [15:0] t_on [4];
    for (int p = 0; p < 8; p++) begin
      host.wr(`PMIC_I2C_ADDR, 8'h07, {1'b0, p[2:0], 4'h8}, ok);
      seq_trigger <= 1'b1;
      t_on = '{default: 16'hffff};
      for (int c = 1; c < 380; c++) begin
        @(posedge clk);
        for (int k = 0; k < 4; k++) if (reg_on[k] && t_on[k] === 16'hffff) t_on[k] = c[15:0];
      end
      for (int k = 0; k < 4; k++) chk_dly(t_on[k], 16'(dly_t[p][8*k+:8] * hc));
      seq_trigger <= 1'b0;
      repeat (10) @(posedge clk);
      chk_reg({4'h0, reg_on}, 8'h00);
    end
  endtask : t_sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    t_map();
    t_modes();
    t_unmapped();
    t_status();
    t_enables();
    t_sequence();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule : tb_pmic_control_register_bank
`default_nettype wire
